// ### verification/i2c_host_model.sv
// Behavioural I2C master that drives the port controller's target.
// Assumes pull-ups on SCL and SDA; lines change just after clk_sys falls.
`timescale 1ns/10ps
module i2c_host_model (
    // Clock and bus
    input wire logic clk_sys,
    input wire logic sdaLine,
    output logic sclOut,
    output logic sdaLow
);
    // SCL idles high and stands still outside frames
    initial begin
        sclOut = 1'b1;
        sdaLow = 1'b0;
    end
    // One SCL half period of 80 ns
    task automatic half();
        repeat (8) @(negedge clk_sys);
    endtask : half
    // Start: SDA falls while SCL is high, also used as repeated start
    task automatic startCond();
        sdaLow = 1'b0;
        half();
        sclOut = 1'b1;
        half();
        sdaLow = 1'b1;
        half();
        sclOut = 1'b0;
    endtask : startCond
    // Stop: SDA rises while SCL is high
    task automatic stopCond();
        sdaLow = 1'b1;
        half();
        sclOut = 1'b1;
        half();
        sdaLow = 1'b0;
        half();
    endtask : stopCond
    // One SCL pulse; SDA is taken as SCL rises
    task automatic pulse(output logic seen);
        half();
        sclOut = 1'b1;
        seen = sdaLine;
        half();
        sclOut = 1'b0;
    endtask : pulse
    // Send a byte MSB first and return the target's acknowledge
    task automatic sendByte(input logic [7:0] b, output logic ack);
        logic seen;
        for (int i = 7; i >= 0; i--) begin
            sdaLow = ~b[i];
            pulse(seen);
        end
        sdaLow = 1'b0;
        pulse(seen);
        ack = ~seen;
    endtask : sendByte
    // Receive a byte MSB first, then acknowledge it or not
    task automatic recvByte(input logic last, output logic [7:0] b);
        logic seen;
        sdaLow = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            pulse(seen);
            b[i] = seen;
        end
        sdaLow = ~last;
        pulse(seen);
    endtask : recvByte
endmodule : i2c_host_model

// ### verification/typec_port_mode_ctrl_i2c_target_bench.sv
// Self-checking bench for the Type-C port mode controller and its I2C target.
// Assumes the host model is compiled first; SDA is resolved here from both enables.
`timescale 1ns/10ps
module typec_port_mode_ctrl_i2c_target_bench import port_ctrl_pkg::*;;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic sclOut, sdaLow, sdaOeN, enableN, busPowerSense, ccPullUp, shutdown, ack;
    logic attachIndOeN, curAOeN, curBOeN, alertOeN;
    logic [1:0] roleStrap, addrStrap;
    cc_sense_t ccIn;
    int err_total = 0;
    int samples_checked = 0;
    int hi, lo;
    wire logic sdaLine = ~sdaLow & sdaOeN;
    // Clock and parts
    always #5 clk_sys = ~clk_sys;
    typec_port_mode_ctrl_i2c_target #(.ACCESS_DELAY_CYCLES(20), .TOGGLE_CYCLES(50)) dut (
        .clk_sys(clk_sys), .reset(reset), .sclIn(sclOut), .sdaIn(sdaLine),
        .sdaOeN(sdaOeN), .roleStrap(roleStrap), .addrStrap(addrStrap), .enableN(enableN),
        .busPowerSense(busPowerSense), .ccSense(ccIn), .ccPullUp(ccPullUp),
        .shutdown(shutdown), .attachIndOeN(attachIndOeN), .curAOeN(curAOeN),
        .curBOeN(curBOeN), .alertOeN(alertOeN));
    i2c_host_model host (.clk_sys(clk_sys), .sdaLine(sdaLine), .sclOut(sclOut), .sdaLow(sdaLow));
    // Compare and count
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Reset, then wait past the access delay
    task automatic doReset();
        reset = 1'b1;
        repeat (8) @(negedge clk_sys);
        reset = 1'b0;
        repeat (30) @(negedge clk_sys);
    endtask : doReset
    // Write: address, sub-address, then n data bytes taken from the top of d
    task automatic regWrite(input logic [7:0] sub, input logic [15:0] d, input int n);
        host.startCond();
        host.sendByte(8'h8e, ack);
        check("ack write address", 8'h01, {7'h0, ack});
        host.sendByte(sub, ack);
        check("ack sub-address", 8'h01, {7'h0, ack});
        for (int i = 0; i < n; i++) begin
            host.sendByte(d[15 - 8 * i -: 8], ack);
            check("ack data", 8'h01, {7'h0, ack});
        end
        host.stopCond();
    endtask : regWrite
    // Read n bytes from the pointer, last one not acknowledged
    task automatic regRead(input int n, input logic [15:0] exp);
        logic [7:0] b;
        host.startCond();
        host.sendByte(8'h8f, ack);
        check("ack read address", 8'h01, {7'h0, ack});
        for (int i = 0; i < n; i++) begin
            host.recvByte(i == n - 1, b);
            check("read data", exp[15 - 8 * i -: 8], b);
        end
        host.stopCond();
    endtask : regRead
    // Print the counts and the verdict
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run
    // Watchdog
    initial begin
        #500000;
        err_total++;
        complete_run();
    end
    // Test sequence
    initial begin
        roleStrap = 2'h0;
        addrStrap = 2'h0;
        enableN = 1'b0;
        busPowerSense = 1'b0;
        ccIn = '0;
        doReset();
        check("pull-up", 8'h00, {7'h0, ccPullUp});
        check("shutdown", 8'h00, {7'h0, shutdown});
        host.startCond();
        host.sendByte(8'hce, ack);
        check("ack foreign address", 8'h00, {7'h0, ack});
        host.stopCond();
        regWrite(8'h09, 16'h1600, 1);
        regWrite(8'h08, 16'h0000, 0);
        regRead(1, 16'h0000);
        regRead(2, 16'h2600);
        regWrite(8'h09, 16'h0220, 2);
        for (int i = 0; i < 100 && ccPullUp !== 1'b1; i++) @(negedge clk_sys);
        check("override source", 8'h01, {7'h0, ccPullUp});
        ccIn.ccSinkSeen = 1'b1;
        for (int i = 0; i < 3000 && attachIndOeN !== 1'b0; i++) @(negedge clk_sys);
        check("indicator", 8'h00, {7'h0, attachIndOeN});
        repeat (2) @(negedge clk_sys);
        check("alert", 8'h00, {7'h0, alertOeN});
        regWrite(8'h0a, 16'h1000, 1);
        regWrite(8'h09, 16'h0000, 0);
        regRead(2, 16'h7220);
        regWrite(8'h09, 16'h1200, 1);
        repeat (10) @(negedge clk_sys);
        check("alert released", 8'h01, {7'h0, alertOeN});
        ccIn.ccSinkSeen = 1'b0;
        for (int i = 0; i < 3000 && attachIndOeN !== 1'b1; i++) @(negedge clk_sys);
        check("detach", 8'h01, {7'h0, attachIndOeN});
        regWrite(8'h0a, 16'h1000, 1);
        repeat (10) @(negedge clk_sys);
        check("override sink", 8'h00, {7'h0, ccPullUp});
        regWrite(8'h0a, 16'h3000, 1);
        hi = 0;
        lo = 0;
        repeat (300) begin
            @(negedge clk_sys);
            if (ccPullUp === 1'b1) hi++;
            if (ccPullUp === 1'b0) lo++;
        end
        check("toggle", 8'h01, {7'h0, hi > 0 && lo > 0});
        enableN = 1'b1;
        repeat (20) @(negedge clk_sys);
        check("shutdown on", 8'h01, {7'h0, shutdown});
        check("sink terms", 8'h00, {7'h0, ccPullUp});
        enableN = 1'b0;
        addrStrap = 2'h2;
        doReset();
        ccIn.ccSourceSeen = 1'b1;
        ccIn.ccCurrent = 2'h1;
        busPowerSense = 1'b1;
        for (int i = 0; i < 3000 && curAOeN !== 1'b0; i++) @(negedge clk_sys);
        check("current a", 8'h00, {7'h0, curAOeN});
        check("current b", 8'h01, {7'h0, curBOeN});
        busPowerSense = 1'b0;
        for (int i = 0; i < 3000 && curAOeN !== 1'b1; i++) @(negedge clk_sys);
        check("sink detach", 8'h01, {7'h0, curAOeN});
        ccIn = 5'h04; // Audio accessory seen only
        for (int i = 0; i < 3000 && alertOeN !== 1'b0; i++) @(negedge clk_sys);
        check("audio", 8'h00, {7'h0, alertOeN});
        complete_run();
    end
endmodule : typec_port_mode_ctrl_i2c_target_bench

// ### verilog/port_ctrl_pkg.sv
// Types shared by the Type-C port mode controller.
// Assumes the constants header is compiled alongside.
package port_ctrl_pkg;
    typedef enum logic [1:0] {STRAP_LOW, STRAP_HIGH, STRAP_FLOAT} strap_t;
    typedef enum logic [1:0] {ROLE_UFP, ROLE_DFP, ROLE_DRP} role_t;
    typedef enum logic [2:0] {
        M_SHUT, M_UNSNK, M_UNSRC, M_ATTSNK, M_ATTSRC, M_AUDIO
    } mode_t;
    typedef enum logic [2:0] {I_IDLE, I_ADDR, I_SUB, I_WR, I_RD} i2c_t;
    typedef struct packed {
        logic ccSourceSeen;
        logic ccSinkSeen;
        logic ccAudioSeen;
        logic [1:0] ccCurrent;
    } cc_sense_t;
endpackage : port_ctrl_pkg

// ### verilog/typec_port_cfg.svh
// Constants for the Type-C port mode controller and its I2C target.
// Assumes a 100 MHz system clock and is included by the design by bare name.
// Operation
// - In I2C mode the alert pin is pulled low when registers change.
// - The change pending flag is set whenever the alert pin is low.
// - In GPIO mode the audio pin is low while audio accessory is attached.
// - Bus power decides sink attach, detach and accessory exit; accessory entry does not look at it.
// - A dual-role port uses bus power to finish role resolution.
// - After reset start as unattached sink until attach is confirmed.
// - An unattached dual-role port alternates between sink and source.
// - Role override writes take effect only while unattached.
// - The role strap is sampled only at reset; later only I2C changes role.
// - Source attach shows on the indicator pin; sink on the current pins in GPIO mode.
// - Leave active on removal, sink bus power loss, or enable released.
// - Enable high means shutdown with sink pull-downs on both CC pins.
// - No I2C access is accepted before the host access delay.
// - Target address is 1100111 with strap high, 1000111 with strap low.
// - Write: start, address with write flag, and the address byte is acked.
// - A one-byte sub-address follows, MSB first, and is acked.
// - Each following data byte is acked; the master ends with stop.
// - Read: start, address with read flag, and the address byte is acked.
// - Reads go MSB first from the written sub-address, last read plus one, or zero.
// - After a read byte a not-acknowledge ends the read before stop.
// - The change pending flag is bit 4 of register 0x09 and sticks.
// - Override code 00 strap, 01 sink, 10 source, 11 dual-role.
`ifndef TYPEC_PORT_CFG_SVH
`define TYPEC_PORT_CFG_SVH

`define CLK_PERIOD_NS 10
`define HOST_ACCESS_DELAY_NS 1000
`define DRP_TOGGLE_NS 50000
`define STRAP_SETTLE 2'h3
`define SYNC_RESET 13'h1800

`define ADDR_HIGH 7'h67
`define ADDR_LOW 7'h47

`define REG_DETECT 8'h08
`define REG_STATUS 8'h09
`define REG_MODE 8'h0a

`define PEND_BIT 4
`define DUTY_LSB 1
`define NOACC_BIT 0
`define OVR_LSB 4
`define CABLE_DIR_DEFAULT 1'b1

`define OVR_KEEP 2'h0
`define OVR_UFP 2'h1
`define OVR_DFP 2'h2

`define ACC_NONE 3'h0
`define ACC_AUDIO 3'h4
`define ATT_NONE 2'h0
`define ATT_SRC 2'h1
`define ATT_SNK 2'h2
`define ATT_ACC 2'h3
`define CUR_DEFAULT 2'h0
`define CUR_MEDIUM 2'h1
`define CUR_HIGH 2'h3

`endif

// ### verilog/typec_port_mode_ctrl_i2c_target.sv
// Port mode control and I2C target for a Type-C configuration-channel controller.
// Assumes all pin inputs are asynchronous and that the pad ring resolves
// open-drain levels from the enables; driven pins are always pulled low.
`timescale 1ns/10ps
`include "typec_port_cfg.svh"
module typec_port_mode_ctrl_i2c_target
    import port_ctrl_pkg::*;
#(
    parameter int ACCESS_DELAY_CYCLES = `HOST_ACCESS_DELAY_NS / `CLK_PERIOD_NS,
    parameter int TOGGLE_CYCLES = `DRP_TOGGLE_NS / `CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // I2C pins
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOeN,
    // Straps and control pins
    input wire logic [1:0] roleStrap,
    input wire logic [1:0] addrStrap,
    input wire logic enableN,
    input wire logic busPowerSense,
    // Analog CC sensing results
    input cc_sense_t ccSense,
    // Port outputs
    output logic ccPullUp,
    output logic shutdown,
    output logic attachIndOeN,
    output logic curAOeN,
    output logic curBOeN,
    output logic alertOeN
);
    localparam int SW = 13;
    localparam int DW = $clog2(ACCESS_DELAY_CYCLES + 1);
    localparam int TW = $clog2(TOGGLE_CYCLES + 1);
    // SCL and SDA synchronise to their idle high level so no false edge follows reset
    localparam logic [SW-1:0] SYNC_RST = `SYNC_RESET;

    logic [SW-1:0] rawIn;
    logic [SW-1:0] meta_reg;
    logic [SW-1:0] sync_reg;
    logic scl, sda, enN, vbus;
    cc_sense_t cc;
    logic [1:0] roleBits, addrBits;
    logic sclPrev_reg, sdaPrev_reg;
    logic sclRise, sclFall, startCond, stopCond;
    logic [1:0] settle_reg;
    logic strapDone_reg;
    strap_t roleStrap_reg, addrStrap_reg;
    logic [DW-1:0] delayCnt_reg;
    logic hostReady_reg;
    logic i2cMode, accessOk, unatt;
    logic [6:0] ownAddr;
    role_t strapRole, effRole;
    mode_t mode_reg, mode_next;
    logic [TW-1:0] toggleCnt_reg;
    logic toggleDone;
    logic [1:0] override_reg, duty_reg, detect_reg;
    logic noUfpAcc_reg, pending_reg, clearHit, changed;
    logic [2:0] accCode;
    logic [1:0] attCode;
    logic [6:0] prevStatus_reg;
    logic [7:0] rdByte;
    i2c_t i2cSt_reg;
    logic [3:0] bitCnt_reg;
    logic ackPh_reg, nack_reg, wrStb_reg, byteEnd;
    logic [7:0] shift_reg, ptr_reg, wrAddr_reg, wrData_reg;

    // Two-flop synchronisers for every pin input
    assign rawIn = {sclIn, sdaIn, enableN, busPowerSense, ccSense, roleStrap, addrStrap};
    for (genvar g = 0; g < SW; g++) begin : gSync
        always_ff @(posedge clk_sys or posedge reset) begin
            if (reset) begin
                meta_reg[g] <= SYNC_RST[g];
                sync_reg[g] <= SYNC_RST[g];
            end else begin
                meta_reg[g] <= rawIn[g];
                sync_reg[g] <= meta_reg[g];
            end
        end
    end
    assign {scl, sda, enN, vbus, cc, roleBits, addrBits} = sync_reg;

    // Bus edge and start/stop detection
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sclPrev_reg <= 1'b1;
            sdaPrev_reg <= 1'b1;
        end else begin
            sclPrev_reg <= scl;
            sdaPrev_reg <= sda;
        end
    end
    assign sclRise = scl & ~sclPrev_reg;
    assign sclFall = ~scl & sclPrev_reg;
    assign startCond = scl & sclPrev_reg & sdaPrev_reg & ~sda;
    assign stopCond = scl & sclPrev_reg & ~sdaPrev_reg & sda;

    // Straps caught once after the synchronisers settle
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            settle_reg <= 2'h0;
            strapDone_reg <= 1'b0;
            roleStrap_reg <= STRAP_FLOAT;
            addrStrap_reg <= STRAP_FLOAT;
        end else if (!strapDone_reg) begin
            settle_reg <= settle_reg + 2'h1;
            if (settle_reg == `STRAP_SETTLE) begin
                strapDone_reg <= 1'b1;
                roleStrap_reg <= strap_t'(roleBits);
                addrStrap_reg <= strap_t'(addrBits);
            end
        end
    end

    // Host access delay after reset
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            delayCnt_reg <= '0;
            hostReady_reg <= 1'b0;
        end else if (!hostReady_reg) begin
            delayCnt_reg <= delayCnt_reg + DW'(1);
            hostReady_reg <= delayCnt_reg == DW'(ACCESS_DELAY_CYCLES - 1);
        end
    end

    assign i2cMode = strapDone_reg && addrStrap_reg != STRAP_FLOAT;
    assign accessOk = i2cMode && hostReady_reg && mode_reg != M_SHUT;
    assign ownAddr = addrStrap_reg == STRAP_HIGH ? `ADDR_HIGH : `ADDR_LOW;
    assign unatt = mode_reg == M_UNSNK || mode_reg == M_UNSRC;

    // Effective role from strap and override
    always_comb begin
        unique case (roleStrap_reg)
            STRAP_HIGH: strapRole = ROLE_DFP;
            STRAP_LOW: strapRole = ROLE_UFP;
            default: strapRole = ROLE_DRP;
        endcase
        unique case (override_reg)
            `OVR_KEEP: effRole = strapRole;
            `OVR_UFP: effRole = ROLE_UFP;
            `OVR_DFP: effRole = ROLE_DFP;
            default: effRole = ROLE_DRP;
        endcase
    end

    // Dual-role toggle timer
    assign toggleDone = toggleCnt_reg == TW'(TOGGLE_CYCLES - 1);
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            toggleCnt_reg <= '0;
        end else if (mode_next != mode_reg || toggleDone) begin
            toggleCnt_reg <= '0;
        end else begin
            toggleCnt_reg <= toggleCnt_reg + TW'(1);
        end
    end

    // Port mode next state
    always_comb begin
        mode_next = mode_reg;
        unique case (mode_reg)
            M_SHUT: if (!enN) mode_next = M_UNSNK;
            M_UNSNK: begin
                if (effRole == ROLE_DFP) begin
                    mode_next = M_UNSRC;
                end else if (cc.ccSourceSeen && vbus) begin
                    mode_next = M_ATTSNK;
                end else if (cc.ccAudioSeen && !noUfpAcc_reg) begin
                    mode_next = M_AUDIO;
                end else if (effRole == ROLE_DRP && toggleDone) begin
                    mode_next = M_UNSRC;
                end
            end
            M_UNSRC: begin
                if (effRole == ROLE_UFP) begin
                    mode_next = M_UNSNK;
                end else if (cc.ccAudioSeen) begin
                    mode_next = M_AUDIO;
                end else if (cc.ccSinkSeen && (effRole == ROLE_DFP || !vbus)) begin
                    mode_next = M_ATTSRC;
                end else if (effRole == ROLE_DRP && toggleDone) begin
                    mode_next = M_UNSNK;
                end
            end
            M_ATTSNK: if (!cc.ccSourceSeen || !vbus) mode_next = M_UNSNK;
            M_ATTSRC: if (!cc.ccSinkSeen) mode_next = M_UNSNK;
            M_AUDIO: if (!cc.ccAudioSeen && !vbus) mode_next = M_UNSNK;
        endcase
        if (enN) begin
            mode_next = M_SHUT;
        end
        if (!strapDone_reg) begin
            mode_next = M_UNSNK;
        end
    end

    // Port mode register, starts unattached as sink
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            mode_reg <= M_UNSNK;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // Status fields seen by software
    assign accCode = mode_reg == M_AUDIO ? `ACC_AUDIO : `ACC_NONE;
    always_comb begin
        unique case (mode_reg)
            M_ATTSRC: attCode = `ATT_SRC;
            M_ATTSNK: attCode = `ATT_SNK;
            M_AUDIO: attCode = `ATT_ACC;
            default: attCode = `ATT_NONE;
        endcase
    end
    assign changed = {detect_reg, accCode, attCode} != prevStatus_reg;
    assign clearHit = wrStb_reg && wrAddr_reg == `REG_STATUS && wrData_reg[`PEND_BIT];

    // Software registers and the sticky change flag
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            override_reg <= `OVR_KEEP;
            duty_reg <= 2'h0;
            noUfpAcc_reg <= 1'b0;
            detect_reg <= `CUR_DEFAULT;
            prevStatus_reg <= {`CUR_DEFAULT, `ACC_NONE, `ATT_NONE};
            pending_reg <= 1'b0;
        end else begin
            prevStatus_reg <= {detect_reg, accCode, attCode};
            if (mode_next == M_ATTSNK && mode_reg != M_ATTSNK) begin
                detect_reg <= cc.ccCurrent;
            end else if (mode_next != M_ATTSNK) begin
                detect_reg <= `CUR_DEFAULT;
            end
            if (wrStb_reg && wrAddr_reg == `REG_STATUS) begin
                duty_reg <= wrData_reg[`DUTY_LSB +: 2];
                noUfpAcc_reg <= wrData_reg[`NOACC_BIT];
            end
            if (wrStb_reg && wrAddr_reg == `REG_MODE && unatt) begin
                override_reg <= wrData_reg[`OVR_LSB +: 2];
            end
            if (clearHit) begin
                pending_reg <= 1'b0;
            end
            if (changed) begin
                pending_reg <= 1'b1;
            end
        end
    end

    // Register read data at the pointer
    always_comb begin
        unique case (ptr_reg)
            `REG_DETECT: rdByte = {2'h0, detect_reg, accCode, 1'b0};
            `REG_STATUS: rdByte = {attCode, `CABLE_DIR_DEFAULT, pending_reg, 1'b0, duty_reg,
                noUfpAcc_reg};
            `REG_MODE: rdByte = {2'h0, override_reg, 4'h0};
            default: rdByte = 8'h00;
        endcase
    end

    // I2C target byte engine
    assign byteEnd = sclFall && !ackPh_reg && bitCnt_reg == 4'h8;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            i2cSt_reg <= I_IDLE;
            bitCnt_reg <= 4'h0;
            ackPh_reg <= 1'b0;
            nack_reg <= 1'b0;
            shift_reg <= 8'h00;
            ptr_reg <= 8'h00;
            sdaOeN <= 1'b1;
            wrStb_reg <= 1'b0;
            wrAddr_reg <= 8'h00;
            wrData_reg <= 8'h00;
        end else begin
            wrStb_reg <= 1'b0;
            if (!accessOk || stopCond) begin
                i2cSt_reg <= I_IDLE;
                ackPh_reg <= 1'b0;
                sdaOeN <= 1'b1;
            end else if (startCond) begin
                i2cSt_reg <= I_ADDR;
                bitCnt_reg <= 4'h0;
                ackPh_reg <= 1'b0;
                nack_reg <= 1'b0;
                sdaOeN <= 1'b1;
            end else if (i2cSt_reg != I_IDLE && sclRise) begin
                if (ackPh_reg) begin
                    nack_reg <= sda;
                end else begin
                    bitCnt_reg <= bitCnt_reg + 4'h1;
                    if (i2cSt_reg != I_RD) begin
                        shift_reg <= {shift_reg[6:0], sda};
                    end
                end
            end else if (i2cSt_reg != I_IDLE && byteEnd) begin
                ackPh_reg <= 1'b1;
                bitCnt_reg <= 4'h0;
                unique case (i2cSt_reg)
                    I_ADDR: begin
                        if (shift_reg[7:1] == ownAddr) begin
                            sdaOeN <= 1'b0;
                            i2cSt_reg <= shift_reg[0] ? I_RD : I_SUB;
                        end else begin
                            i2cSt_reg <= I_IDLE;
                        end
                    end
                    I_SUB: begin
                        ptr_reg <= shift_reg;
                        sdaOeN <= 1'b0;
                        i2cSt_reg <= I_WR;
                    end
                    I_WR: begin
                        wrStb_reg <= 1'b1;
                        wrAddr_reg <= ptr_reg;
                        wrData_reg <= shift_reg;
                        ptr_reg <= ptr_reg + 8'h01;
                        sdaOeN <= 1'b0;
                    end
                    I_RD: sdaOeN <= 1'b1;
                    I_IDLE: ;
                endcase
            end else if (i2cSt_reg != I_IDLE && sclFall && ackPh_reg) begin
                ackPh_reg <= 1'b0;
                if (i2cSt_reg == I_RD && nack_reg) begin
                    i2cSt_reg <= I_IDLE;
                    sdaOeN <= 1'b1;
                end else if (i2cSt_reg == I_RD) begin
                    shift_reg <= rdByte;
                    sdaOeN <= rdByte[7];
                    ptr_reg <= ptr_reg + 8'h01;
                end else begin
                    sdaOeN <= 1'b1;
                end
            end else if (i2cSt_reg == I_RD && sclFall) begin
                shift_reg <= {shift_reg[6:0], 1'b0};
                sdaOeN <= shift_reg[6];
            end
        end
    end

    // Registered port pins
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ccPullUp <= 1'b0;
            shutdown <= 1'b0;
            attachIndOeN <= 1'b1;
            curAOeN <= 1'b1;
            curBOeN <= 1'b1;
            alertOeN <= 1'b1;
        end else begin
            ccPullUp <= mode_reg == M_UNSRC || mode_reg == M_ATTSRC;
            shutdown <= mode_reg == M_SHUT;
            attachIndOeN <= mode_reg != M_ATTSRC;
            curAOeN <= !(!i2cMode && mode_reg == M_ATTSNK && detect_reg[0]);
            curBOeN <= !(!i2cMode && mode_reg == M_ATTSNK &&
                detect_reg != `CUR_MEDIUM);
            alertOeN <= !((i2cMode && pending_reg) ||
                (!i2cMode && mode_reg == M_AUDIO));
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence addrMatch;
        i2cSt_reg == I_ADDR && byteEnd && shift_reg[7:1] == ownAddr && accessOk &&
            !startCond && !stopCond;
    endsequence
    sequence readNack;
        i2cSt_reg == I_RD && ackPh_reg && nack_reg && sclFall && accessOk &&
            !startCond && !stopCond;
    endsequence

    chk_alert_low: assert property (i2cMode && pending_reg |=> !alertOeN)
        else $error("alert not driven while change pending");
    chk_pend_set: assert property (changed |=> pending_reg)
        else $error("change pending flag not set");
    chk_pend_sticky: assert property (pending_reg && !clearHit |=> pending_reg)
        else $error("change pending flag dropped without clear");
    chk_audio_pin: assert property (!i2cMode && mode_reg == M_AUDIO |=> !alertOeN)
        else $error("audio pin not low in GPIO mode");
    chk_sink_detach: assert property (mode_reg == M_ATTSNK && !vbus && !enN &&
        strapDone_reg |=> mode_reg == M_UNSNK)
        else $error("sink stayed attached without bus power");
    chk_role_lock: assert property (wrStb_reg && !unatt |=> $stable(override_reg))
        else $error("role override changed while attached");
    chk_strap_once: assert property (strapDone_reg |=> $stable(roleStrap_reg))
        else $error("role strap resampled");
    chk_src_ind: assert property (mode_reg == M_ATTSRC |=> !attachIndOeN)
        else $error("source attach not indicated");
    chk_shut_rd: assert property (enN && strapDone_reg |=> mode_reg == M_SHUT ##1
        !ccPullUp && shutdown)
        else $error("shutdown without sink terminations");
    chk_no_early: assert property (!hostReady_reg |-> i2cSt_reg == I_IDLE && sdaOeN)
        else $error("I2C active before access delay");
    chk_addr_ack: assert property (addrMatch |=> !sdaOeN && ackPh_reg)
        else $error("address byte not acknowledged");
    chk_read_nack: assert property (readNack |=> i2cSt_reg == I_IDLE && sdaOeN)
        else $error("read continued after not-acknowledge");
    chk_ptr_step: assert property (i2cSt_reg == I_WR && byteEnd && accessOk && !startCond &&
        !stopCond |=> wrStb_reg && ptr_reg == $past(ptr_reg) + 8'h01)
        else $error("pointer did not advance after write byte");
endmodule : typec_port_mode_ctrl_i2c_target
